// ==== hw/ubc_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Baud generation and receiver/transmitter enable control
module ubc_top
(
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe_n_o,
	input  wire logic        rx_char_busy_i,
	input  wire logic        tx_shift_busy_i,
	input  wire logic        tx_hold_full_i,
	input  wire logic        tx_guard_busy_i,
	output logic             rx_enabled_o,
	output logic             tx_enabled_o,
	output logic             rx_soft_rst_o,
	output logic             tx_soft_rst_o,
	output logic             sample_tick_o,
	output logic             baud_tick_o,
	output logic             etu_tick_o
);
	logic [31:0] mode_reg;
	logic [31:0] mode_next;
	logic [15:0] cd_reg;
	logic [15:0] cd_next;
	logic [2:0]  fp_reg;
	logic [2:0]  fp_next;
	logic [10:0] ratio_reg;
	logic [10:0] ratio_next;
	logic        rx_en_reg;
	logic        rx_en_next;
	logic        tx_en_reg;
	logic        tx_en_next;
	logic        rx_stop_reg;
	logic        rx_stop_next;
	logic        tx_stop_reg;
	logic        tx_stop_next;
	logic        rx_rst_reg;
	logic        rx_rst_next;
	logic        tx_rst_reg;
	logic        tx_rst_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        sck_m1_reg;
	logic        sck_m2_reg;
	logic        sck_m3_reg;
	logic [2:0]  pre_reg;
	logic [2:0]  pre_next;
	logic        src_tick;
	logic        div_pulse;
	logic        div_level;
	logic [3:0]  over_cnt_reg;
	logic [3:0]  over_cnt_next;
	logic [10:0] etu_cnt_reg;
	logic [10:0] etu_cnt_next;
	logic        smp_reg;
	logic        smp_next;
	logic        baud_reg;
	logic        baud_next;
	logic        etu_reg;
	logic        etu_next;
	logic        sck_reg;
	logic        sck_next;
	logic        sck_oe_n_reg;
	logic        sck_oe_n_next;
	logic        is_sync;
	logic        is_iso;
	logic        is_normal;
	logic        over;
	logic [1:0]  clk_sel;
	logic [2:0]  fp_eff;
	logic        ext_bypass;

	// Field decoding used by several paths
	function automatic logic is_write(input logic [3:0] a, input logic [3:0] target, input logic w);
		is_write = w && (a == target);
	endfunction

	assign is_sync    = mode_reg[ubc_pkg::MODE_SYNC];
	assign over       = mode_reg[ubc_pkg::MODE_OVER];
	assign clk_sel    = mode_reg[ubc_pkg::MODE_CLK_LSB +: 2];
	assign is_iso     = (mode_reg[ubc_pkg::MODE_OP_LSB +: 4] == ubc_pkg::OP_ISO_T0)
		|| (mode_reg[ubc_pkg::MODE_OP_LSB +: 4] == ubc_pkg::OP_ISO_T1);
	assign is_normal  = (mode_reg[ubc_pkg::MODE_OP_LSB +: 4] == ubc_pkg::OP_NORMAL) && !is_sync;
	assign fp_eff     = is_normal ? fp_reg : 3'h0;
	assign ext_bypass = is_sync && (clk_sel == ubc_pkg::CLK_EXT);

	// External clock synchroniser and edge detect
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sck_m1_reg <= 1'b0;
			sck_m2_reg <= 1'b0;
			sck_m3_reg <= 1'b0;
		end
		else
		begin
			sck_m1_reg <= sck_i;
			sck_m2_reg <= sck_m1_reg;
			sck_m3_reg <= sck_m2_reg;
		end
	end

	// Source select with fixed prescaler
	always_comb
	begin
		pre_next = pre_reg + 3'h1;
		case (clk_sel)
			ubc_pkg::CLK_MCK:     src_tick = 1'b1;
			ubc_pkg::CLK_MCK_DIV: src_tick = (pre_reg == 3'(ubc_pkg::MCK_DIV - 1));
			ubc_pkg::CLK_EXT:     src_tick = sck_m2_reg && !sck_m3_reg;
			default:              src_tick = 1'b1;
		endcase
	end

	ubc_div u_div
	(
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.tick_i    (src_tick),
		.div_i     (cd_reg),
		.frac_i    (fp_eff),
		.pulse_o   (div_pulse),
		.level_o   (div_level)
	);

	// Register writes and direction control
	always_comb
	begin
		mode_next    = mode_reg;
		cd_next      = cd_reg;
		fp_next      = fp_reg;
		ratio_next   = ratio_reg;
		rx_en_next   = rx_en_reg;
		tx_en_next   = tx_en_reg;
		rx_stop_next = rx_stop_reg;
		tx_stop_next = tx_stop_reg;
		rx_rst_next  = 1'b0;
		tx_rst_next  = 1'b0;
		if (is_write(addr_i, ubc_pkg::ADDR_MODE, wr_i))
			mode_next = wdata_i;
		if (is_write(addr_i, ubc_pkg::ADDR_BAUD, wr_i))
		begin
			cd_next = wdata_i[15:0];
			fp_next = wdata_i[ubc_pkg::BAUD_FP_LSB +: 3];
		end
		if (is_write(addr_i, ubc_pkg::ADDR_RATIO, wr_i))
			ratio_next = wdata_i[10:0];
		// Pending disables finish once traffic drains
		if (rx_stop_reg && !rx_char_busy_i)
		begin
			rx_en_next   = 1'b0;
			rx_stop_next = 1'b0;
		end
		if (tx_stop_reg && !tx_shift_busy_i && !tx_hold_full_i && !tx_guard_busy_i)
		begin
			tx_en_next   = 1'b0;
			tx_stop_next = 1'b0;
		end
		if (is_write(addr_i, ubc_pkg::ADDR_CTRL, wr_i))
		begin
			if (wdata_i[ubc_pkg::CTRL_RX_EN])
			begin
				rx_en_next   = 1'b1;
				rx_stop_next = 1'b0;
			end
			if (wdata_i[ubc_pkg::CTRL_TX_EN])
			begin
				tx_en_next   = 1'b1;
				tx_stop_next = 1'b0;
			end
			if (wdata_i[ubc_pkg::CTRL_RX_DIS] && (rx_en_next || rx_en_reg))
			begin
				rx_stop_next = rx_char_busy_i;
				rx_en_next   = rx_char_busy_i && rx_en_reg;
			end
			if (wdata_i[ubc_pkg::CTRL_TX_DIS] && (tx_en_next || tx_en_reg))
			begin
				tx_stop_next = tx_shift_busy_i || tx_hold_full_i || tx_guard_busy_i;
				tx_en_next   = tx_stop_next && tx_en_reg;
				if (!tx_en_next)
					tx_stop_next = 1'b0;
			end
			if (!rx_en_next)
				rx_stop_next = 1'b0;
			if (wdata_i[ubc_pkg::CTRL_RST_RX])
				rx_rst_next = 1'b1;
			if (wdata_i[ubc_pkg::CTRL_RST_TX])
				tx_rst_next = 1'b1;
		end
	end

	// Read mux, answered the cycle after the strobe
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		if (rd_i)
		begin
			case (addr_i)
				ubc_pkg::ADDR_MODE:  rdata_next = mode_reg;
				ubc_pkg::ADDR_BAUD:  rdata_next = {13'h0000, fp_reg, cd_reg};
				ubc_pkg::ADDR_RATIO: rdata_next = {21'h000000, ratio_reg};
				ubc_pkg::ADDR_STAT:  rdata_next = {28'h0000000, tx_stop_reg, rx_stop_reg, tx_en_reg, rx_en_reg};
				default:             rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// Oversampling, baud and card bit-time ticks
	always_comb
	begin
		over_cnt_next = over_cnt_reg;
		etu_cnt_next  = etu_cnt_reg;
		smp_next      = 1'b0;
		baud_next     = 1'b0;
		etu_next      = 1'b0;
		sck_next      = sck_reg;
		sck_oe_n_next = 1'b1;
		if (ext_bypass)
		begin
			baud_next = src_tick;
			smp_next  = src_tick;
		end
		else if (is_sync)
		begin
			baud_next     = div_pulse;
			smp_next      = div_pulse;
			sck_next      = div_level;
			sck_oe_n_next = 1'b0;
		end
		else if (is_iso)
		begin
			sck_next      = div_level;
			sck_oe_n_next = !mode_reg[ubc_pkg::MODE_CARD_CLOCK_OUTPUT_ENABLE];
			if (div_pulse)
			begin
				if (etu_cnt_reg + 11'h001 >= ratio_reg)
				begin
					etu_cnt_next = 11'h000;
					etu_next     = (ratio_reg != 11'h000);
					baud_next    = (ratio_reg != 11'h000);
				end
				else
					etu_cnt_next = etu_cnt_reg + 11'h001;
			end
		end
		else if (div_pulse)
		begin
			smp_next = 1'b1;
			if (over_cnt_reg == (over ? 4'h7 : 4'hF))
			begin
				over_cnt_next = 4'h0;
				baud_next     = 1'b1;
			end
			else
				over_cnt_next = over_cnt_reg + 4'h1;
		end
	end

	// State registers
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			mode_reg     <= ubc_pkg::MODE_RST;
			cd_reg       <= ubc_pkg::CD_RST;
			fp_reg       <= ubc_pkg::FP_RST;
			ratio_reg    <= ubc_pkg::RATIO_RST;
			rx_en_reg    <= 1'b0;
			tx_en_reg    <= 1'b0;
			rx_stop_reg  <= 1'b0;
			tx_stop_reg  <= 1'b0;
			rx_rst_reg   <= 1'b0;
			tx_rst_reg   <= 1'b0;
			rdata_reg    <= 32'h0000_0000;
			pre_reg      <= 3'h0;
			over_cnt_reg <= 4'h0;
			etu_cnt_reg  <= 11'h000;
			smp_reg      <= 1'b0;
			baud_reg     <= 1'b0;
			etu_reg      <= 1'b0;
			sck_reg      <= 1'b0;
			sck_oe_n_reg <= 1'b1;
		end
		else
		begin
			mode_reg     <= mode_next;
			cd_reg       <= cd_next;
			fp_reg       <= fp_next;
			ratio_reg    <= ratio_next;
			rx_en_reg    <= rx_en_next;
			tx_en_reg    <= tx_en_next;
			rx_stop_reg  <= rx_stop_next;
			tx_stop_reg  <= tx_stop_next;
			rx_rst_reg   <= rx_rst_next;
			tx_rst_reg   <= tx_rst_next;
			rdata_reg    <= rdata_next;
			pre_reg      <= pre_next;
			over_cnt_reg <= over_cnt_next;
			etu_cnt_reg  <= etu_cnt_next;
			smp_reg      <= smp_next;
			baud_reg     <= baud_next;
			etu_reg      <= etu_next;
			sck_reg      <= sck_next;
			sck_oe_n_reg <= sck_oe_n_next;
		end
	end

	assign rdata_o       = rdata_reg;
	assign sck_o         = sck_reg;
	assign sck_oe_n_o    = sck_oe_n_reg;
	assign rx_enabled_o  = rx_en_reg;
	assign tx_enabled_o  = tx_en_reg;
	assign rx_soft_rst_o = rx_rst_reg;
	assign tx_soft_rst_o = tx_rst_reg;
	assign sample_tick_o = smp_reg;
	assign baud_tick_o   = baud_reg;
	assign etu_tick_o    = etu_reg;
endmodule
`default_nettype wire

// ==== include/ubc_pkg.sv ====
// Overview of operation
// - Divisor zero stops the baud clock; divisor one bypasses the divider.
// - Clock source is master clock, master clock over eight, or external pin.
// - Nonzero fractional field enables eighth-step fractional division.
// - Fractional division applies only in normal asynchronous mode.
// - Async baud is source over 8*(2-over)*(divisor+frac/8).
// - Sync baud clock is source divided by the integer divisor only.
// - Sync with source 3 uses the external clock undivided, divisor ignored.
// - Master clock source in sync mode gives 50:50 serial clock for even divisors; odd ones above one stay high one tick less than low.
// - Smart-card mode divides by divisor and drives card clock when enabled.
// - Smart-card sampling divider divides card clock by ratio up to 2047.
// - Card ratio field resets to 0x174, i.e. 372 card clocks per bit.
// - Receiver stays disabled after reset until its enable bit is written.
// - Transmitter stays disabled after reset until its enable bit is written.
// - Receiver configuration accepts writes while disabled and is used once enabled.
// - Soft reset clears status and state of its direction, keeping configuration.
// - Soft reset aborts that direction's communication immediately.
// - Receiver disable lets the current character finish first.
// - Transmitter disable lets shifting and holding characters finish first.
// - Timeguard is still inserted when transmitter is disabled while active.
package ubc_pkg;
	localparam logic [3:0] ADDR_CTRL  = 4'h0;
	localparam logic [3:0] ADDR_MODE  = 4'h1;
	localparam logic [3:0] ADDR_BAUD  = 4'h2;
	localparam logic [3:0] ADDR_RATIO = 4'h3;
	localparam logic [3:0] ADDR_STAT  = 4'h4;
	// Control bits
	localparam int CTRL_RST_RX = 2;
	localparam int CTRL_RST_TX = 3;
	localparam int CTRL_RX_EN  = 4;
	localparam int CTRL_RX_DIS = 5;
	localparam int CTRL_TX_EN  = 6;
	localparam int CTRL_TX_DIS = 7;
	// Mode fields
	localparam int MODE_OP_LSB  = 0;
	localparam int MODE_CLK_LSB = 4;
	localparam int MODE_SYNC    = 8;
	localparam int MODE_OVER    = 19;
	localparam int MODE_CARD_CLOCK_OUTPUT_ENABLE    = 18;
	// Baud fields
	localparam int BAUD_FP_LSB = 16;
	// Operating modes
	localparam logic [3:0] OP_NORMAL = 4'h0;
	localparam logic [3:0] OP_ISO_T0 = 4'h4;
	localparam logic [3:0] OP_ISO_T1 = 4'h6;
	// Clock sources
	localparam logic [1:0] CLK_MCK     = 2'h0;
	localparam logic [1:0] CLK_MCK_DIV = 2'h1;
	localparam logic [1:0] CLK_EXT     = 2'h3;
	localparam int         MCK_DIV     = 8;
	// Reset values
	localparam logic [31:0] MODE_RST  = 32'h0000_0000;
	localparam logic [15:0] CD_RST    = 16'h0000;
	localparam logic [2:0]  FP_RST    = 3'h0;
	localparam logic [10:0] RATIO_RST = 11'h174;
endpackage

// ==== hw/ubc_div.sv ====
`timescale 1ns/10ps
`default_nettype none
// Divider with eighth-step fraction and 50:50 output on even divisors
module ubc_div
(
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire logic        tick_i,
	input  wire logic [15:0] div_i,
	input  wire logic [2:0]  frac_i,
	output logic             pulse_o,
	output logic             level_o
);
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [2:0]  acc_reg;
	logic [2:0]  acc_next;
	logic        lvl_reg;
	logic        lvl_next;
	logic [15:0] period;
	logic [3:0]  sum;
	logic [15:0] high_len;

	// Next count; fraction adds frac_i extra ticks every eight periods on average
	always_comb
	begin
		sum       = {1'b0, acc_reg} + {1'b0, frac_i};
		period    = div_i + {15'h0000, sum[3]};
		high_len  = {1'b0, period[15:1]};
		cnt_next  = cnt_reg;
		acc_next  = acc_reg;
		lvl_next  = lvl_reg;
		pulse_o   = 1'b0;
		if (div_i == 16'h0000)
		begin
			cnt_next = 16'h0000;
			lvl_next = 1'b0;
		end
		else if (tick_i)
		begin
			if (div_i == 16'h0001)
			begin
				pulse_o  = 1'b1;
				lvl_next = ~lvl_reg;
			end
			else if (cnt_reg + 16'h0001 >= period)
			begin
				cnt_next  = 16'h0000;
				acc_next  = sum[2:0];
				pulse_o   = 1'b1;
				lvl_next  = 1'b1;
			end
			else
			begin
				cnt_next = cnt_reg + 16'h0001;
				if (cnt_reg + 16'h0001 == high_len)
					lvl_next = 1'b0;
			end
		end
		level_o = lvl_reg;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cnt_reg  <= 16'h0000;
			acc_reg  <= 3'h0;
			lvl_reg  <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			acc_reg  <= acc_next;
			lvl_reg  <= lvl_next;
		end
	end
endmodule
`default_nettype wire

// ==== verification/ubc_far_clk.sv ====
`timescale 1ns/10ps
`default_nettype none
// External serial clock source, held low outside frames
module ubc_far_clk
(
	input  wire logic clk_sys_i,
	input  wire logic run_i,
	output logic      sck_o
);
	logic [3:0] cnt_reg;
	// Half period of five system cycles keeps it ten times slower
	always_ff @(posedge clk_sys_i)
	begin
		if (!run_i)
		begin
			cnt_reg <= 4'h0;
			sck_o <= 1'b0;
		end
		else if (cnt_reg == 4'h4)
		begin
			cnt_reg <= 4'h0;
			sck_o <= ~sck_o;
		end
		else
			cnt_reg <= cnt_reg + 4'h1;
	end
endmodule
`default_nettype wire

// ==== verification/ubc_top_props.sv ====
`timescale 1ns/10ps
`default_nettype none
// Enable, soft reset and stopped-divider checks at the top ports
module ubc_top_props
(
	input wire logic        clk_sys_i,
	input wire logic        nrst_i,
	input wire logic [3:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rx_char_busy_i,
	input wire logic        tx_shift_busy_i,
	input wire logic        tx_hold_full_i,
	input wire logic        tx_guard_busy_i,
	input wire logic        rx_enabled_o,
	input wire logic        tx_enabled_o,
	input wire logic        rx_soft_rst_o,
	input wire logic        tx_soft_rst_o,
	input wire logic        sample_tick_o,
	input wire logic        baud_tick_o
);
	logic ctl_w;
	logic cd0_reg;
	logic ext_reg;
	assign ctl_w = wr_i && addr_i == ubc_pkg::ADDR_CTRL;
	// Track a zero divisor and the undivided external source
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cd0_reg <= 1'b1;
			ext_reg <= 1'b0;
		end
		else if (wr_i && addr_i == ubc_pkg::ADDR_BAUD)
			cd0_reg <= wdata_i[15:0] == 16'h0000;
		else if (wr_i && addr_i == ubc_pkg::ADDR_MODE)
			ext_reg <= wdata_i[8] && wdata_i[5:4] == 2'h3;
	end
	default clocking dc @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);
	a_rx_en_cause: assert property ($rose(rx_enabled_o) |-> $past(ctl_w && wdata_i[4] && !wdata_i[5]))
		else $error("receiver enabled without a write");
	a_tx_en_cause: assert property ($rose(tx_enabled_o) |-> $past(ctl_w && wdata_i[6] && !wdata_i[7]))
		else $error("transmitter enabled without a write");
	a_rx_rst_pulse: assert property (ctl_w && wdata_i[2] |=> rx_soft_rst_o)
		else $error("receiver soft reset pulse missing");
	a_tx_rst_cause: assert property (tx_soft_rst_o |-> $past(ctl_w && wdata_i[3]))
		else $error("transmitter soft reset without a write");
	a_rx_drain_wait: assert property ($fell(rx_enabled_o) |-> !$past(rx_char_busy_i))
		else $error("receiver stopped mid character");
	a_tx_drain_wait: assert property ($fell(tx_enabled_o) |->
		!$past(tx_shift_busy_i || tx_hold_full_i || tx_guard_busy_i))
		else $error("transmitter stopped before draining");
	a_rx_dis_wins: assert property (ctl_w && wdata_i[4] && wdata_i[5] && !rx_char_busy_i |=> !rx_enabled_o)
		else $error("receiver enabled despite disable");
	a_zero_quiet: assert property (cd0_reg && $past(cd0_reg, 3) && !ext_reg && !$past(ext_reg)
		|-> !baud_tick_o && !sample_tick_o)
		else $error("ticks with zero divisor");
endmodule
bind ubc_top ubc_top_props u_props (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rx_char_busy_i,
	.tx_shift_busy_i, .tx_hold_full_i, .tx_guard_busy_i, .rx_enabled_o, .tx_enabled_o, .rx_soft_rst_o,
	.tx_soft_rst_o, .sample_tick_o, .baud_tick_o);
`default_nettype wire

// ==== verification/ubc_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module ubc_top_tb;
	logic        clk_sys_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [3:0]  addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        rx_char_busy_i = 1'b0;
	logic [2:0]  txb = 3'h0;
	logic        run = 1'b0;
	wire logic   sck_i;
	logic [31:0] rdata_o;
	logic        sck_o, sck_oe_n_o, rx_enabled_o, tx_enabled_o, rx_soft_rst_o, tx_soft_rst_o;
	logic        sample_tick_o, baud_tick_o, etu_tick_o;
	logic [31:0] d;
	int          c;
	int          k;
	int          rt;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	logic [31:0] tm [7] = '{32'h0008_0000, 32'h0, 32'h100, 32'h110, 32'h100, 32'h0004_0004, 32'h130};
	logic [31:0] tbv [7] = '{32'h2, 32'h0004_0002, 32'h3, 32'h2, 32'h1, 32'h0004_0002, 32'h5};
	int          ts [7] = '{0, 0, 0, 0, 0, 1, 0};
	int          te [7] = '{32, 80, 6, 32, 2, 48, 20};

	always #20 clk_sys_i = ~clk_sys_i;

	ubc_top DUT (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sck_i, .sck_o, .sck_oe_n_o,
		.rx_char_busy_i, .tx_shift_busy_i(txb[0]), .tx_hold_full_i(txb[1]), .tx_guard_busy_i(txb[2]),
		.rx_enabled_o, .tx_enabled_o, .rx_soft_rst_o, .tx_soft_rst_o, .sample_tick_o, .baud_tick_o, .etu_tick_o);
	ubc_far_clk u_far (.clk_sys_i, .run_i(run), .sck_o(sck_i));

	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One-cycle register write, effect settled on return
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask

	// Cycles spanned by n tick periods of the chosen output
	task automatic per(input int sel, input int n, output int cy);
		int kk;
		cy = 0;
		kk = -1;
		while (kk < n && cy < 4000)
		begin
			@(posedge clk_sys_i);
			#1;
			if (kk >= 0)
				cy++;
			if ((sel == 0 ? baud_tick_o : etu_tick_o) === 1'b1)
				kk++;
		end
		if (cy >= 4000)
		begin
			n_mismatch++;
			results();
		end
	endtask

	// Card clocks per bit, nearest integer of the decoded division over adjustment factors
	function automatic int ratio_of(input logic [3:0] clock_division_code, input logic [3:0] bit_rate_adjust_code);
		int divf;
		int adj;
		case (clock_division_code)
			4'h2:    divf = 558;
			4'h3:    divf = 744;
			4'h4:    divf = 1116;
			4'h5:    divf = 1488;
			4'h6:    divf = 1860;
			4'h9:    divf = 512;
			4'hA:    divf = 768;
			4'hB:    divf = 1024;
			4'hC:    divf = 1536;
			4'hD:    divf = 2048;
			default: divf = 372;
		endcase
		case (bit_rate_adjust_code)
			4'h2:    adj = 2;
			4'h3:    adj = 4;
			4'h4:    adj = 8;
			4'h5:    adj = 16;
			4'h6:    adj = 32;
			4'h8:    adj = 12;
			4'h9:    adj = 20;
			default: adj = 1;
		endcase
		ratio_of = (divf + adj / 2) / adj;
	endfunction

	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		rd(ubc_pkg::ADDR_RATIO, d);
		chk(d, 32'h174);
		chk({rx_enabled_o, tx_enabled_o, sck_oe_n_o}, 3'b001);
		rd(4'hF, d);
		chk(d, 32'h0);
		wr(ubc_pkg::ADDR_BAUD, 32'h0004_0009);
		wr(ubc_pkg::ADDR_CTRL, 32'hF0);
		chk({rx_enabled_o, tx_enabled_o}, 2'b00);
		wr(ubc_pkg::ADDR_CTRL, 32'h50);
		chk({rx_enabled_o, tx_enabled_o}, 2'b11);
		rd(ubc_pkg::ADDR_BAUD, d);
		chk(d, 32'h0004_0009);
		$display("test enables done");
		wr(ubc_pkg::ADDR_CTRL, 32'h0C);
		chk({rx_soft_rst_o, tx_soft_rst_o, rx_enabled_o, tx_enabled_o}, 4'hF);
		rd(ubc_pkg::ADDR_BAUD, d);
		chk(d, 32'h0004_0009);
		$display("test soft reset done");
		@(posedge clk_sys_i);
		rx_char_busy_i <= 1'b1;
		txb <= 3'h7;
		wr(ubc_pkg::ADDR_CTRL, 32'hA0);
		rd(ubc_pkg::ADDR_STAT, d);
		chk(d[3:0], 4'hF);
		@(posedge clk_sys_i);
		rx_char_busy_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk(rx_enabled_o, 1'b0);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk_sys_i);
			txb[i] <= 1'b0;
			repeat (3) @(posedge clk_sys_i);
			#1;
			chk(tx_enabled_o, i < 2);
		end
		$display("test drain done");
		wr(ubc_pkg::ADDR_CTRL, 32'h50);
		wr(ubc_pkg::ADDR_MODE, 32'h0);
		wr(ubc_pkg::ADDR_BAUD, 32'h0);
		k = 0;
		repeat (300)
		begin
			@(posedge clk_sys_i);
			#1;
			if (baud_tick_o === 1'b1 || sample_tick_o === 1'b1)
				k++;
		end
		chk(k, 0);
		rt = ratio_of(4'h1, 4'h6);
		chk((rt * 3200 >= 372 * 95) && (rt * 3200 <= 372 * 105), 1'b1);
		wr(ubc_pkg::ADDR_RATIO, 32'(rt));
		for (int i = 0; i < 7; i++)
		begin
			@(posedge clk_sys_i);
			run <= (i == 6);
			wr(ubc_pkg::ADDR_MODE, tm[i]);
			wr(ubc_pkg::ADDR_BAUD, tbv[i]);
			per(ts[i], 1, c);
			per(ts[i], 2, c);
			chk(c, te[i]);
			if (i == 5)
				chk(sck_oe_n_o, 1'b0);
			// Even divisor on the divided master clock gives a balanced serial clock
			if (i == 3)
			begin
				k = 0;
				repeat (32)
				begin
					@(posedge clk_sys_i);
					#1;
					if (sck_o === 1'b1)
						k++;
				end
				chk(k, 16);
			end
		end
		run <= 1'b0;
		$display("test baud done");
		results();
	end
endmodule
`default_nettype wire
